// File: core/usas_pkg.sv
// Package of constants and types for the unaligned store and barrier unit
// Behaviour
// - Right-part store is decoded from primary opcode 101110 with base, source, offset fields
// - Effective address is the sign-extended 16-bit offset plus the base register
// - Right-part store writes the low one to four bytes within the aligned word
// - Only the low 32 bits of a 64-bit source register are stored
// - Written bytes depend on low address bits and the core byte order
// - 32-bit right store: index is address XOR endian, shift left, size word minus index
// - 64-bit path places data in the half chosen by address bit 2 XOR endian
// - 64-bit path XORs physical bits with reverse flag, clears two when memory little
// - 64-bit left store right-justifies the source top bytes, size equals index
// - Only translation, bus and address errors; no alignment check on the address
// - A right and a left store together write the whole unaligned word
// - Barrier decoded from special opcode function 001111, bits 25 to 11 zero
// - Barrier waits until all earlier accesses are globally performed before later ones
// - Ordering types 1 to 31 behave exactly as type zero
// - Barrier orders only uncached and cached coherent shared memory accesses
// - Barrier need not order instruction fetches against data accesses
// - Load completes at register write; store when visible to every processor
// - A store is performed for an agent once its later load returns the value
// - A load is performed for an agent once its later store cannot change it
// - On a strongly ordered system the barrier is a no-operation, not an error
// - 32-bit left store right-justifies the source top bytes, size equals index
package usas_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] USAS_OFF_CTRL = 8'h00;
   localparam logic [7:0] USAS_OFF_INSTR = 8'h04;
   localparam logic [7:0] USAS_OFF_BASE_LO = 8'h08;
   localparam logic [7:0] USAS_OFF_BASE_HI = 8'h0c;
   localparam logic [7:0] USAS_OFF_SRC = 8'h10;
   localparam logic [7:0] USAS_OFF_STATUS = 8'h14;
   localparam logic [7:0] USAS_OFF_ADDR_LO = 8'h18;
   localparam logic [7:0] USAS_OFF_DATA_LO = 8'h1c;
   localparam logic [7:0] USAS_OFF_DATA_HI = 8'h20;
   localparam logic [7:0] USAS_OFF_LANES = 8'h24;
   // ----------------------------------------
   // Control bits and reset value
   // ----------------------------------------
   localparam int USAS_CTRL_CORE_BIG = 0;
   localparam int USAS_CTRL_MEM_BIG = 1;
   localparam int USAS_CTRL_REVERSE = 2;
   localparam int USAS_CTRL_WIDE = 3;
   localparam int USAS_CTRL_STRONG = 4;
   localparam logic [4:0] USAS_CTRL_RESET = 5'h00;
   // ----------------------------------------
   // Instruction encodings
   // ----------------------------------------
   localparam logic [5:0] USAS_OP_RIGHT = 6'h2e;
   localparam logic [5:0] USAS_OP_LEFT = 6'h2a;
   localparam logic [5:0] USAS_OP_SPECIAL = 6'h00;
   localparam logic [5:0] USAS_FN_BARRIER = 6'h0f;
   // ----------------------------------------
   // Exception codes and bus answers
   // ----------------------------------------
   localparam logic [2:0] USAS_EXC_NONE = 3'h0;
   localparam logic [2:0] USAS_EXC_REFILL = 3'h1;
   localparam logic [2:0] USAS_EXC_INVALID = 3'h2;
   localparam logic [2:0] USAS_EXC_MODIFIED = 3'h3;
   localparam logic [2:0] USAS_EXC_BUS = 3'h4;
   localparam logic [2:0] USAS_EXC_ADDRESS = 3'h5;
   localparam logic [1:0] USAS_RESP_OKAY = 2'h0;
   localparam logic [1:0] USAS_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      USAS_ST_IDLE = 2'b00,
      USAS_ST_STORE = 2'b01,
      USAS_ST_SYNC = 2'b10
   } usas_state_e;
endpackage : usas_pkg

// File: core/usas_unit.sv
// Unaligned partial word store and memory barrier unit with AXI4-Lite registers
`timescale 1ns/100ps
module usas_unit (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic mem_req,
   output logic [63:0] mem_addr,
   output logic [63:0] mem_data,
   output logic [7:0] mem_lanes,
   output logic [1:0] mem_size,
   input wire logic mem_ack,
   input wire logic [2:0] mem_err,
   output logic sync_req,
   input wire logic sync_ack
);
   import usas_pkg::*;

   typedef struct packed {
      usas_state_e st;
      logic [4:0] ctrl;
      logic [31:0] instr;
      logic [63:0] base;
      logic [31:0] src;
      logic req;
      logic [63:0] addr;
      logic [63:0] data;
      logic [7:0] lanes;
      logic [1:0] size;
      logic sreq;
      logic [2:0] exc;
      logic done;
      logic rsvd;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } usas_s;

   usas_s q_r;
   usas_s q_nxt;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] usas_merge(input logic [31:0] old, input logic [31:0] val,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = val[8*i +: 8];
         end
      end
      return res;
   endfunction : usas_merge

   function automatic logic usas_mapped(input logic [7:0] a);
      return (a <= USAS_OFF_LANES) && (a[1:0] == 2'b00);
   endfunction : usas_mapped

   logic wr_fire;
   logic launch;
   logic is_right;
   logic is_left;
   logic is_barrier;
   logic [63:0] ea;
   logic [1:0] byt;
   logic [31:0] word;
   logic [3:0] lanes4;
   logic [1:0] code;
   logic [63:0] pa;
   logic hlf;
   logic [31:0] ctrl_w;

   // ----------------------------------------
   // Decode and data path
   // ----------------------------------------
   always_comb begin
      wr_fire = q_r.aw_got && q_r.w_got && !q_r.bvalid;
      launch = wr_fire && (q_r.aw_addr == USAS_OFF_INSTR) && (q_r.st == USAS_ST_IDLE);
      is_right = q_r.w_data[31:26] == USAS_OP_RIGHT;
      is_left = q_r.w_data[31:26] == USAS_OP_LEFT;
      is_barrier = (q_r.w_data[31:26] == USAS_OP_SPECIAL) && (q_r.w_data[5:0] == USAS_FN_BARRIER)
                   && (q_r.w_data[25:11] == 15'h0000);
      ea = q_r.base + {{48{q_r.w_data[15]}}, q_r.w_data[15:0]};
      ctrl_w = usas_merge({27'h0, q_r.ctrl}, q_r.w_data, q_r.w_strb);
      byt = ea[1:0] ^ {2{q_r.ctrl[USAS_CTRL_CORE_BIG]}};
      if (is_right) begin
         word = q_r.src << {byt, 3'b000};
         lanes4 = 4'hf << byt;
         code = 2'd3 - byt;
      end else begin
         word = q_r.src >> (5'd24 - {byt, 3'b000});
         lanes4 = 4'hf >> (2'd3 - byt);
         code = byt;
      end
      pa = ea;
      hlf = 1'b0;
      if (q_r.ctrl[USAS_CTRL_WIDE]) begin
         pa[2:0] = ea[2:0] ^ {3{q_r.ctrl[USAS_CTRL_REVERSE]}};
         hlf = ea[2] ^ q_r.ctrl[USAS_CTRL_CORE_BIG];
      end else begin
         pa[1:0] = ea[1:0] ^ {2{q_r.ctrl[USAS_CTRL_REVERSE]}};
      end
      if (!q_r.ctrl[USAS_CTRL_MEM_BIG]) begin
         pa[1:0] = 2'b00;
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      q_nxt = q_r;
      // Write address and data taken independently
      if (s_axi_awvalid && q_r.awready) begin
         q_nxt.aw_got = 1'b1;
         q_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q_r.wready) begin
         q_nxt.w_got = 1'b1;
         q_nxt.w_data = s_axi_wdata;
         q_nxt.w_strb = s_axi_wstrb;
      end
      if (q_r.bvalid && s_axi_bready) begin
         q_nxt.bvalid = 1'b0;
      end
      // Register write once both halves are held
      if (wr_fire) begin
         q_nxt.aw_got = 1'b0;
         q_nxt.w_got = 1'b0;
         q_nxt.bvalid = 1'b1;
         q_nxt.bresp = USAS_RESP_OKAY;
         case (q_r.aw_addr)
            USAS_OFF_CTRL: begin
               q_nxt.ctrl = ctrl_w[4:0];
            end
            USAS_OFF_BASE_LO: begin
               q_nxt.base[31:0] = usas_merge(q_r.base[31:0], q_r.w_data, q_r.w_strb);
            end
            USAS_OFF_BASE_HI: begin
               q_nxt.base[63:32] = usas_merge(q_r.base[63:32], q_r.w_data, q_r.w_strb);
            end
            USAS_OFF_SRC: begin
               q_nxt.src = usas_merge(q_r.src, q_r.w_data, q_r.w_strb);
            end
            USAS_OFF_INSTR: begin
               if (q_r.st != USAS_ST_IDLE) begin
                  q_nxt.bresp = USAS_RESP_SLVERR;
               end
            end
            default: begin
               if (!usas_mapped(q_r.aw_addr)) begin
                  q_nxt.bresp = USAS_RESP_SLVERR;
               end
            end
         endcase
      end
      // Execution
      case (q_r.st)
         USAS_ST_IDLE: begin
            if (launch) begin
               q_nxt.instr = q_r.w_data;
               q_nxt.done = 1'b0;
               q_nxt.rsvd = 1'b0;
               q_nxt.exc = USAS_EXC_NONE;
               if (is_right || is_left) begin
                  q_nxt.req = 1'b1;
                  q_nxt.addr = pa;
                  q_nxt.size = code;
                  q_nxt.data = hlf ? {word, 32'h0000_0000} : {32'h0000_0000, word};
                  q_nxt.lanes = hlf ? {lanes4, 4'h0} : {4'h0, lanes4};
                  q_nxt.st = USAS_ST_STORE;
               end else if (is_barrier) begin
                  // Any ordering type is run as type zero
                  if (q_r.ctrl[USAS_CTRL_STRONG]) begin
                     q_nxt.done = 1'b1;
                  end else begin
                     q_nxt.sreq = 1'b1;
                     q_nxt.st = USAS_ST_SYNC;
                  end
               end else begin
                  q_nxt.rsvd = 1'b1;
                  q_nxt.done = 1'b1;
               end
            end
         end
         USAS_ST_STORE: begin
            if (mem_ack) begin
               q_nxt.req = 1'b0;
               q_nxt.exc = mem_err;
               q_nxt.done = 1'b1;
               q_nxt.st = USAS_ST_IDLE;
            end
         end
         USAS_ST_SYNC: begin
            if (sync_ack) begin
               q_nxt.sreq = 1'b0;
               q_nxt.done = 1'b1;
               q_nxt.st = USAS_ST_IDLE;
            end
         end
         default: begin
            q_nxt.st = USAS_ST_IDLE;
         end
      endcase
      q_nxt.awready = !q_nxt.aw_got && !q_nxt.bvalid;
      q_nxt.wready = !q_nxt.w_got && !q_nxt.bvalid;
      // Read channel
      if (q_r.rvalid && s_axi_rready) begin
         q_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q_r.arready) begin
         q_nxt.rvalid = 1'b1;
         q_nxt.rresp = usas_mapped(s_axi_araddr) ? USAS_RESP_OKAY : USAS_RESP_SLVERR;
         case (s_axi_araddr)
            USAS_OFF_CTRL: q_nxt.rdata = {27'h0, q_r.ctrl};
            USAS_OFF_INSTR: q_nxt.rdata = q_r.instr;
            USAS_OFF_BASE_LO: q_nxt.rdata = q_r.base[31:0];
            USAS_OFF_BASE_HI: q_nxt.rdata = q_r.base[63:32];
            USAS_OFF_SRC: q_nxt.rdata = q_r.src;
            USAS_OFF_STATUS: begin
               q_nxt.rdata = {24'h0, q_r.rsvd, q_r.exc, q_r.done, q_r.sreq, q_r.req,
                              q_r.st != USAS_ST_IDLE};
            end
            USAS_OFF_ADDR_LO: q_nxt.rdata = q_r.addr[31:0];
            USAS_OFF_DATA_LO: q_nxt.rdata = q_r.data[31:0];
            USAS_OFF_DATA_HI: q_nxt.rdata = q_r.data[63:32];
            USAS_OFF_LANES: q_nxt.rdata = {22'h0, q_r.size, q_r.lanes};
            default: q_nxt.rdata = 32'h0000_0000;
         endcase
      end
      q_nxt.arready = !q_nxt.rvalid;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q_r <= '0;
         q_r.st <= USAS_ST_IDLE;
         q_r.ctrl <= USAS_CTRL_RESET;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign s_axi_awready = q_r.awready;
   assign s_axi_wready = q_r.wready;
   assign s_axi_bvalid = q_r.bvalid;
   assign s_axi_bresp = q_r.bresp;
   assign s_axi_arready = q_r.arready;
   assign s_axi_rvalid = q_r.rvalid;
   assign s_axi_rdata = q_r.rdata;
   assign s_axi_rresp = q_r.rresp;
   assign mem_req = q_r.req;
   assign mem_addr = q_r.addr;
   assign mem_data = q_r.data;
   assign mem_lanes = q_r.lanes;
   assign mem_size = q_r.size;
   assign sync_req = q_r.sreq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking usas_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_store_launch: assert property (
      launch && (is_right || is_left) |=> mem_req ##0 mem_size == $past(code))
      else $error("partial store not issued");
   chk_req_hold: assert property (
      mem_req && !mem_ack |=> mem_req && $stable(mem_data) && $stable(mem_lanes))
      else $error("store request dropped or changed");
   chk_lane_count: assert property (
      mem_req |-> $countones(mem_lanes) == 32'(mem_size) + 1)
      else $error("lane count differs from size");
   chk_half_only: assert property (
      mem_req |-> (mem_lanes[7:4] == 4'h0) || (mem_lanes[3:0] == 4'h0))
      else $error("lanes span both halves");
   chk_left_size: assert property (
      launch && is_left |=> mem_size == $past(byt))
      else $error("left store size not index");
   chk_no_align: assert property (
      launch && (is_right || is_left) |=> mem_req && q_r.exc == USAS_EXC_NONE)
      else $error("alignment fault raised");
   chk_strong_nop: assert property (
      launch && is_barrier && q_r.ctrl[USAS_CTRL_STRONG] |=>
         !sync_req && q_r.done && !q_r.rsvd)
      else $error("strong barrier not a no-op");
   chk_sync_hold: assert property (
      sync_req && !sync_ack |=> sync_req [*1] ##0 q_r.st == USAS_ST_SYNC)
      else $error("barrier released early");
   chk_stype_any: assert property (
      launch && is_barrier |=> !q_r.rsvd && (sync_req || q_r.done))
      else $error("ordering type refused");
   chk_mem_little: assert property (
      mem_req && !q_r.ctrl[USAS_CTRL_MEM_BIG] |-> mem_addr[1:0] == 2'b00)
      else $error("low address bits not cleared");
endmodule : usas_unit

// File: testbench/usas_mem_model.sv
// Memory system model answering partial stores and barriers
`timescale 1ns/100ps
module usas_mem_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic mem_req,
   input wire logic [63:0] mem_addr,
   input wire logic [63:0] mem_data,
   input wire logic [7:0] mem_lanes,
   input wire logic [1:0] mem_size,
   output logic mem_ack,
   output logic [2:0] mem_err,
   input wire logic sync_req,
   output logic sync_ack,
   input wire logic [3:0] delay,
   input wire logic [2:0] err_code,
   output logic [137:0] cap,
   output logic [7:0] sync_n,
   output logic [7:0] faults
);
   logic [3:0] cnt;
   logic [137:0] prev;
   logic held;
   logic sync_d;
   // Code valid only beside the acknowledge
   assign mem_err = mem_ack ? err_code : ~err_code;
   always @(posedge aclk) begin
      if (!aresetn) begin
         mem_ack <= 1'b0;
         sync_ack <= 1'b0;
         cnt <= 4'h0;
         held <= 1'b0;
         sync_d <= 1'b0;
         sync_n <= 8'h0;
         faults <= 8'h0;
      end else begin
         mem_ack <= 1'b0;
         sync_ack <= 1'b0;
         sync_d <= sync_req;
         held <= mem_req && !mem_ack;
         prev <= {mem_addr, mem_data, mem_lanes, mem_size};
         if (sync_req && !sync_d) sync_n <= sync_n + 8'h1;
         // Payload must stay put while offered
         if (held && mem_req && prev !== {mem_addr, mem_data, mem_lanes, mem_size})
            faults <= faults + 8'h1;
         if (mem_req && !mem_ack) begin
            cnt <= cnt + 4'h1;
            if (cnt == delay) begin
               mem_ack <= 1'b1;
               cnt <= 4'h0;
               cap <= {mem_addr, mem_data, mem_lanes, mem_size};
            end
         end
         // Barrier released only with no store outstanding
         if (sync_req && !sync_ack && !mem_req) begin
            cnt <= cnt + 4'h1;
            if (cnt == delay) begin
               sync_ack <= 1'b1;
               cnt <= 4'h0;
            end
         end
      end
   end
endmodule : usas_mem_model

// File: testbench/usas_unit_test.sv
// Self-checking bench of the unaligned store and barrier unit
`timescale 1ns/100ps
module usas_unit_test;
   import usas_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic bvalid, arready, rvalid, mem_req, mem_ack, sync_req, sync_ack;
   logic [7:0] awaddr, araddr, mem_lanes, sync_n, faults;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, delay;
   logic [1:0] bresp, rresp, mem_size;
   logic [63:0] mem_addr, mem_data;
   logic [2:0] mem_err, err_code;
   logic [137:0] cap;
   int errors, checked;
   usas_unit dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_data(mem_data), .mem_lanes(mem_lanes), .mem_size(mem_size),
      .mem_ack(mem_ack), .mem_err(mem_err), .sync_req(sync_req), .sync_ack(sync_ack));
   usas_mem_model mem_u (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_data(mem_data), .mem_lanes(mem_lanes),
      .mem_size(mem_size), .mem_ack(mem_ack), .mem_err(mem_err), .sync_req(sync_req),
      .sync_ack(sync_ack), .delay(delay), .err_code(err_code), .cap(cap),
      .sync_n(sync_n), .faults(faults));
   // ----------------------------------------
   // Bus tasks and checks
   // ----------------------------------------
   task report_and_stop;
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task cmp(input logic [137:0] g, input logic [137:0] e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask : rd
   task run(input logic [31:0] ins, output logic [31:0] st);
      logic [1:0] r;
      wr(USAS_OFF_INSTR, ins, r);
      st = 32'h0;
      repeat (50) begin
         rd(USAS_OFF_STATUS, st, r);
         if (st[3] === 1'b1) break;
      end
   endtask : run
   function automatic logic [137:0] exp_st(input logic lft, input logic [4:0] c,
         input logic [63:0] ea, input logic [31:0] s);
      logic [1:0] b;
      logic [31:0] w;
      logic [3:0] l;
      logic [63:0] a;
      logic hi;
      b = ea[1:0] ^ {2{c[0]}};
      w = lft ? s >> (24 - 8 * b) : s << (8 * b);
      l = lft ? 4'hf >> (3 - b) : 4'hf << b;
      hi = c[3] & (ea[2] ^ c[0]);
      a = ea ^ {61'h0, c[3] & c[2], {2{c[2]}}};
      if (!c[1]) a[1:0] = 2'h0;
      return {a, hi ? {w, 32'h0} : {32'h0, w}, hi ? {l, 4'h0} : {4'h0, l},
         lft ? b : 2'h3 - b};
   endfunction : exp_st
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task tc_regs;
      logic [1:0] r;
      logic [31:0] d;
      rd(USAS_OFF_CTRL, d, r);
      cmp(d, USAS_CTRL_RESET);
      rd(USAS_OFF_STATUS, d, r);
      cmp(d, 32'h0);
      rd(8'h28, d, r);
      cmp({d, r}, {32'h0, USAS_RESP_SLVERR});
      wr(8'h2c, 32'h1, r);
      cmp(r, USAS_RESP_SLVERR);
   endtask : tc_regs
   task tc_store(input logic lft, input logic [4:0] c, input logic [1:0] k,
         input logic [2:0] e);
      logic [1:0] r;
      logic [31:0] st;
      logic [15:0] off;
      logic [63:0] base;
      logic [63:0] ea;
      off = 16'hfff8 + 16'(5 * k);
      base = {31'h0, c[3], 32'h00002000};
      ea = base + {{48{off[15]}}, off};
      delay <= {2'h0, k};
      err_code <= e;
      wr(USAS_OFF_CTRL, {27'h0, c}, r);
      wr(USAS_OFF_BASE_LO, base[31:0], r);
      wr(USAS_OFF_BASE_HI, base[63:32], r);
      wr(USAS_OFF_SRC, 32'h8a7b6c5d, r);
      run({lft ? USAS_OP_LEFT : USAS_OP_RIGHT, 5'h03, 5'h07, off}, st);
      cmp(cap, exp_st(lft, c, ea, 32'h8a7b6c5d));
      cmp(st[7:4], {1'b0, e});
   endtask : tc_store
   task tc_sync(input logic [31:0] ins, input logic [4:0] c, input logic [7:0] dn,
         input logic rsv);
      logic [1:0] r;
      logic [31:0] st;
      logic [7:0] n0;
      wr(USAS_OFF_CTRL, {27'h0, c}, r);
      n0 = sync_n;
      run(ins, st);
      cmp({sync_n - n0, st[7], st[3]}, {dn, rsv, 1'b1});
   endtask : tc_sync
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      #2000000;
      errors++;
      report_and_stop;
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      delay = 4'h0;
      err_code = 3'h0;
      errors = 0;
      checked = 0;
      aresetn = 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      tc_regs;
      for (int m = 0; m < 4; m++)
         for (int k = 0; k < 4; k++)
            for (int o = 0; o < 2; o++)
               tc_store(o[0], {1'b0, m[1], m[1] & m[0], m[0], m[0]}, k[1:0], 3'h0);
      for (int e = 1; e < 6; e++) tc_store(1'b0, 5'h00, 2'h1, e[2:0]);
      tc_sync({26'h0, USAS_FN_BARRIER}, 5'h00, 8'h1, 1'b0);
      tc_sync({21'h0, 5'h1f, USAS_FN_BARRIER}, 5'h00, 8'h1, 1'b0);
      tc_sync({21'h0, 5'h05, USAS_FN_BARRIER}, 5'h10, 8'h0, 1'b0);
      tc_sync({11'h0, 10'h200, USAS_FN_BARRIER}, 5'h00, 8'h0, 1'b1);
      tc_sync({6'h2b, 26'h0}, 5'h00, 8'h0, 1'b1);
      cmp(faults, 8'h0);
      report_and_stop;
   end
endmodule : usas_unit_test
